// ---- shared/msh_pkg.sv ----
// constants and types for the modem status and host pin block
package msh_pkg;
  localparam logic [3:0] ADR_MSTAT  = 4'h0;
  localparam logic [3:0] ADR_MCTL   = 4'h1;
  localparam logic [3:0] ADR_ISTAT  = 4'h2;
  localparam logic [3:0] ADR_ICLR   = 4'h3;
  localparam logic [3:0] ADR_IEN    = 4'h4;
  localparam logic [3:0] ADR_DCS    = 4'h5;
  localparam logic [3:0] ADR_DEN    = 4'h6;
  localparam logic [3:0] ADR_ICR    = 4'h7;
  localparam logic [3:0] ADR_IRMODE = 4'h8;

  localparam int MCTL_DTR  = 0;
  localparam int MCTL_RTS  = 1;
  localparam int MCTL_LOOP = 4;
  localparam int MCTL_AFE  = 5;

  // modem input order; level at index+4, change at index
  localparam int MI_CTS = 0;
  localparam int MI_DSR = 1;
  localparam int MI_RI  = 2;
  localparam int MI_DCD = 3;

  localparam int EV_MODEM = 0;
  localparam int EV_DACK  = 1;
  localparam int NUM_EV   = 2;
  localparam int NUM_IRQ  = 11;
  localparam int NUM_DRQ  = 3;

  localparam logic [7:0] MCTL_RST  = 8'h00;
  localparam logic [3:0] ICR_RST   = 4'hF;
  localparam logic [1:0] DCS_RST   = 2'h0;
  localparam logic [3:0] PIN_N_RST = 4'hF;

  typedef enum logic [2:0] {
    IRM_SIR   = 3'b000,
    IRM_MIR   = 3'b001,
    IRM_FIR   = 3'b010,
    IRM_ASK   = 3'b011,
    IRM_TV    = 3'b100,
    IRM_UART  = 3'b101
  } msh_irmode_e;
endpackage

// ---- shared/msh_link_if.sv ----
// signals between the core and its modem and routing helpers
`timescale 1ns/1ns
interface msh_link_if;
  logic [3:0]  pin_n;
  logic [3:0]  lvl_n;
  logic [3:0]  chg;
  logic        irq_line;
  logic [3:0]  irq_sel;
  logic        dma_en;
  logic [1:0]  dma_ch;
  logic        dma_src;
  logic [2:0]  dack_n;
  logic [2:0]  drq;
  logic [10:0] irq;
  modport modem (input pin_n, output lvl_n, output chg);
  modport route (input irq_line, input irq_sel, input dma_en, input dma_ch,
                 input dma_src, input dack_n, output drq, output irq);
  modport core (output pin_n, input lvl_n, input chg, output irq_line,
                output irq_sel, output dma_en, output dma_ch, output dma_src,
                output dack_n, input drq, input irq);
endinterface

// ---- hdl/msh_modem_in.sv ----
// modem status inputs: level register and change detect
`timescale 1ns/1ns
module msh_modem_in
  import msh_pkg::*;
(
  input wire logic  clk_in,
  input wire logic  rst_in,
  msh_link_if.modem lnk
);
  typedef struct packed {
    logic [3:0] lvl_n;
    logic [3:0] chg;
  } msh_mod_s;

  msh_mod_s s_reg;
  msh_mod_s s_next;

  always_comb begin
    s_next       = s_reg;
    s_next.lvl_n = lnk.pin_n;
    for (int i = 0; i < 4; i++) begin
      if (i == MI_RI) begin
        s_next.chg[i] = lnk.pin_n[i] & ~s_reg.lvl_n[i]; // low to high only
      end else begin
        s_next.chg[i] = lnk.pin_n[i] ^ s_reg.lvl_n[i]; // any change
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= {PIN_N_RST, 4'h0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.lvl_n = s_reg.lvl_n;
  assign lnk.chg   = s_reg.chg;
endmodule // msh_modem_in

// ---- hdl/msh_host_route.sv ----
// routes the interrupt and dma request onto the selected host lines
`timescale 1ns/1ns
module msh_host_route
  import msh_pkg::*;
(
  input wire logic  clk_in,
  input wire logic  rst_in,
  msh_link_if.route lnk
);
  typedef struct packed {
    logic [NUM_DRQ-1:0] drq;
    logic [NUM_IRQ-1:0] irq;
  } msh_rt_s;

  msh_rt_s          s_reg;
  msh_rt_s          s_next;
  logic [1:0]       ch_idx;
  logic             ch_ok;

  always_comb begin
    s_next = s_reg;
    // channel codes 0, 1, 3 map to lines 0..2; code 2 selects none
    ch_idx = (lnk.dma_ch == 2'h3) ? 2'h2 : lnk.dma_ch;
    ch_ok  = (lnk.dma_ch != 2'h2);
    for (int i = 0; i < NUM_DRQ; i++) begin
      // drop the request while its own acknowledge is low
      s_next.drq[i] = lnk.dma_en & ch_ok & (ch_idx == i[1:0]) & lnk.dma_src
                      & lnk.dack_n[i];
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      s_next.irq[i] = lnk.irq_line & (lnk.irq_sel == i[3:0]);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.drq = s_reg.drq;
  assign lnk.irq = s_reg.irq;

  chk_drq_one_line: assert property (@(posedge clk_in) disable iff (rst_in)
    $onehot0(s_reg.drq)) else $error("more than one dma request");
  chk_irq_sel_line: assert property (@(posedge clk_in) disable iff (rst_in)
    (lnk.irq_line && lnk.irq_sel < 4'hB) |=> s_reg.irq[$past(lnk.irq_sel)])
    else $error("interrupt not on selected line");
endmodule // msh_host_route

// ---- hdl/msh_top.sv ----
// modem status, modem control and host pin logic of the serial controller
`timescale 1ns/1ns
module msh_top
  import msh_pkg::*;
(
  input  wire logic        MCLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CHIP_SEL_N_IN,
  input  wire logic [3:0]  ADDR_IN,
  input  wire logic        WR_STB_IN,
  input  wire logic        RD_STB_IN,
  input  wire logic [7:0]  DATA_IN,
  output logic      [7:0]  DATA_OUT,
  output logic             DATA_OE_OUT,
  input  wire logic        CTS_N_IN,
  input  wire logic        DSR_N_IN,
  input  wire logic        RI_N_IN,
  input  wire logic        DCD_N_IN,
  output logic             DTR_N_OUT,
  output logic             RTS_N_OUT,
  input  wire logic        RX_ABOVE_TRIG_IN,
  output logic             TX_ENABLE_OUT,
  input  wire logic        FAST_IR_RECEIVE_IN,
  input  wire logic        SLOW_IR_RECEIVE_IN,
  output logic             IR_RX_DATA_OUT,
  input  wire logic        DMA_SRC_REQ_IN,
  input  wire logic [2:0]  DACK_N_IN,
  output logic      [2:0]  DRQ_OUT,
  output logic      [10:0] IRQ_OUT
);
  typedef struct packed {
    logic [3:0]        delta;
    logic [7:0]        mctl;
    logic [NUM_EV-1:0] istat;
    logic [NUM_EV-1:0] ien;
    logic [1:0]        dcs;
    logic              dma_en;
    logic [3:0]        icr;
    msh_irmode_e       irmode;
    logic [7:0]        rdata;
    logic              rd_oe;
    logic              dtr_n;
    logic              rts_n;
    logic              tx_en;
    logic              ir_rx;
    logic              irq_line;
  } msh_core_s;

  localparam msh_core_s CORE_RST = '{
    delta: 4'h0, mctl: MCTL_RST, istat: '0, ien: '0, dcs: DCS_RST,
    dma_en: 1'b0, icr: ICR_RST, irmode: IRM_SIR, rdata: 8'h00,
    rd_oe: 1'b0, dtr_n: 1'b1, rts_n: 1'b1, tx_en: 1'b1, ir_rx: 1'b1,
    irq_line: 1'b0};

  msh_core_s  s_reg;
  msh_core_s  s_next;
  msh_link_if lnk ();

  logic              wr_hit;
  logic              rd_hit;
  logic [7:0]        mstat_now;
  logic [3:0]        ev_chg;
  logic [NUM_EV-1:0] ev_set;
  logic              loop_on;
  logic              afe_on;

  msh_modem_in u_modem (
    .clk_in (MCLK_IN),
    .rst_in (RST_IN),
    .lnk    (lnk.modem)
  );

  msh_host_route u_route (
    .clk_in (MCLK_IN),
    .rst_in (RST_IN),
    .lnk    (lnk.route)
  );

  assign lnk.pin_n[MI_CTS] = CTS_N_IN;
  assign lnk.pin_n[MI_DSR] = DSR_N_IN;
  assign lnk.pin_n[MI_RI]  = RI_N_IN;
  assign lnk.pin_n[MI_DCD] = DCD_N_IN;
  assign lnk.irq_line      = s_reg.irq_line;
  assign lnk.irq_sel       = s_reg.icr;
  assign lnk.dma_en        = s_reg.dma_en;
  assign lnk.dma_ch        = s_reg.dcs;
  assign lnk.dma_src       = DMA_SRC_REQ_IN;
  assign lnk.dack_n        = DACK_N_IN;

  always_comb begin
    s_next  = s_reg;
    // chip select gates both strobes; address lines pick the register
    wr_hit  = WR_STB_IN & ~CHIP_SEL_N_IN;
    rd_hit  = RD_STB_IN & ~CHIP_SEL_N_IN;
    loop_on = s_reg.mctl[MCTL_LOOP];
    afe_on  = s_reg.mctl[MCTL_AFE];
    // pins are active low, status shows the asserted state
    mstat_now = {~lnk.lvl_n, s_reg.delta};

    // change bits: a read clears them, a change in the same cycle still sets
    if (rd_hit && ADDR_IN == ADR_MSTAT) begin
      s_next.delta = 4'h0;
    end
    s_next.delta = s_next.delta | lnk.chg;

    // cts change is flow control, not an event, while automatic mode is on
    ev_chg         = lnk.chg;
    ev_chg[MI_CTS] = lnk.chg[MI_CTS] & ~afe_on;
    ev_set           = '0;
    ev_set[EV_MODEM] = |ev_chg;
    ev_set[EV_DACK]  = |(s_reg.dma_en ? ~DACK_N_IN : 3'h0);

    if (wr_hit) begin
      case (ADDR_IN)
        ADR_MCTL:   s_next.mctl   = DATA_IN;
        ADR_ICLR:   s_next.istat  = s_reg.istat & ~DATA_IN[NUM_EV-1:0];
        ADR_IEN:    s_next.ien    = DATA_IN[NUM_EV-1:0];
        ADR_DCS:    s_next.dcs    = DATA_IN[1:0];
        ADR_DEN:    s_next.dma_en = DATA_IN[0];
        ADR_ICR:    s_next.icr    = DATA_IN[3:0];
        ADR_IRMODE: s_next.irmode = msh_irmode_e'(DATA_IN[2:0]);
        default:    s_next.mctl   = s_reg.mctl;
      endcase
    end
    s_next.istat = s_next.istat | ev_set; // set wins over clear

    // read data only in the cycle after the strobe, bit 0 on data line 0
    s_next.rd_oe = rd_hit;
    s_next.rdata = 8'h00;
    if (rd_hit) begin
      case (ADDR_IN)
        ADR_MSTAT:  s_next.rdata = mstat_now;
        ADR_MCTL:   s_next.rdata = s_reg.mctl;
        ADR_ISTAT:  s_next.rdata = {6'h00, s_reg.istat};
        ADR_IEN:    s_next.rdata = {6'h00, s_reg.ien};
        ADR_DCS:    s_next.rdata = {6'h00, s_reg.dcs};
        ADR_DEN:    s_next.rdata = {7'h00, s_reg.dma_en};
        ADR_ICR:    s_next.rdata = {4'h0, s_reg.icr};
        ADR_IRMODE: s_next.rdata = {5'h00, s_reg.irmode};
        default:    s_next.rdata = 8'h00;
      endcase
    end

    s_next.dtr_n = ~(s_reg.mctl[MCTL_DTR] & ~loop_on);
    if (loop_on) begin
      s_next.rts_n = 1'b1;
    end else if (afe_on) begin
      // receiver threshold holds the far end off while data piles up
      s_next.rts_n = ~(s_reg.mctl[MCTL_RTS] & ~RX_ABOVE_TRIG_IN);
    end else begin
      s_next.rts_n = ~s_reg.mctl[MCTL_RTS];
    end
    s_next.tx_en = ~afe_on | ~CTS_N_IN;

    if (s_reg.irmode == IRM_MIR || s_reg.irmode == IRM_FIR) begin
      s_next.ir_rx = FAST_IR_RECEIVE_IN;
    end else begin
      s_next.ir_rx = SLOW_IR_RECEIVE_IN;
    end

    s_next.irq_line = |(s_reg.istat & s_reg.ien);
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      s_reg <= CORE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign DATA_OUT       = s_reg.rdata;
  assign DATA_OE_OUT    = s_reg.rd_oe;
  assign DTR_N_OUT      = s_reg.dtr_n;
  assign RTS_N_OUT      = s_reg.rts_n;
  assign TX_ENABLE_OUT  = s_reg.tx_en;
  assign IR_RX_DATA_OUT = s_reg.ir_rx;
  assign DRQ_OUT        = lnk.drq;
  assign IRQ_OUT        = lnk.irq;

  chk_cts_change_bit: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    lnk.chg[MI_CTS] |=> s_reg.delta[MI_CTS])
    else $error("cts change not recorded");
  chk_cts_no_event: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (afe_on && lnk.chg == 4'h1 && !s_reg.istat[EV_MODEM]
      && !(s_reg.dma_en && DACK_N_IN != 3'h7)) |=> !s_reg.istat[EV_MODEM])
    else $error("cts change raised event in auto mode");
  chk_tx_gate_cts: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (afe_on && CTS_N_IN) |=> !TX_ENABLE_OUT)
    else $error("transmitter not gated by cts");
  chk_dsr_irq_line: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (lnk.chg[MI_DSR] && s_reg.ien[EV_MODEM] && !(wr_hit && ADDR_IN == ADR_IEN))
      |-> ##2 s_reg.irq_line)
    else $error("dsr change gave no interrupt");
  chk_dtr_active: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (s_reg.mctl[MCTL_DTR] && !loop_on) |=> !DTR_N_OUT)
    else $error("dtr not driven low");
  chk_dtr_loop_high: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (loop_on || !s_reg.mctl[MCTL_DTR]) |=> DTR_N_OUT)
    else $error("dtr low in loopback or when clear");
  chk_read_one_cycle: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    rd_hit |=> DATA_OE_OUT ##1 (DATA_OE_OUT == $past(rd_hit)))
    else $error("read data not one cycle after strobe");
  chk_slow_rx_used: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (s_reg.irmode != IRM_MIR && s_reg.irmode != IRM_FIR)
      |=> IR_RX_DATA_OUT == $past(SLOW_IR_RECEIVE_IN))
    else $error("fast receive used in slow mode");
  chk_rts_manual: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (!loop_on && !afe_on) |=> RTS_N_OUT == !$past(s_reg.mctl[MCTL_RTS]))
    else $error("rts does not follow its bit");
  chk_delta_read_clr: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (rd_hit && ADDR_IN == ADR_MSTAT && lnk.chg == 4'h0) |=> s_reg.delta == 4'h0)
    else $error("change bits not cleared by read");
endmodule // msh_top

// ---- verif/msh_dma_model.sv ----
// dma controller model answering each request with a low acknowledge
`timescale 1ns/1ns
module msh_dma_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] drq_in,
  input  wire logic [3:0] lat_in,
  output logic      [2:0] dack_n_out
);
  logic [3:0] cnt_reg;
  // lines idle high as on a pulled-up bus; latency set by the bench
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg    <= 4'h0;
      dack_n_out <= 3'h7;
    end else begin
      cnt_reg    <= (|(drq_in & dack_n_out)) ? cnt_reg + 4'h1 : 4'h0;
      dack_n_out <= (cnt_reg == lat_in) ? ~drq_in : 3'h7;
    end
  end
endmodule // msh_dma_model

// ---- verif/msh_top_tb.sv ----
// self-checking bench for the modem status and host pin block
`timescale 1ns/1ns
module msh_top_tb
  import msh_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  din = 8'h00;
  logic [3:0]  mpin_n = 4'hF;
  logic        trig = 1'b0;
  logic        fir = 1'b0;
  logic        sir = 1'b1;
  logic        src = 1'b0;
  logic [3:0]  lat = 4'h2;
  logic [7:0]  dout;
  logic        doe;
  logic        dtr_n;
  logic        rts_n;
  logic        tx_en;
  logic        ir_rx;
  logic [2:0]  dack_n;
  logic [2:0]  drq;
  logic [10:0] irq;
  logic [3:0]  sel;
  logic        b;
  logic [7:0]  exp_q[$];
  logic [2:0]  dmap[4] = '{3'h1, 3'h2, 3'h0, 3'h4};
  int          fail_count = 0;
  int          total_checks = 0;

  always #5 clk = ~clk;

  msh_top msh_top_inst (.MCLK_IN(clk), .RST_IN(rst), .CHIP_SEL_N_IN(cs_n), .ADDR_IN(addr),
    .WR_STB_IN(wr), .RD_STB_IN(rd), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_OUT(doe),
    .CTS_N_IN(mpin_n[0]), .DSR_N_IN(mpin_n[1]), .RI_N_IN(mpin_n[2]), .DCD_N_IN(mpin_n[3]),
    .DTR_N_OUT(dtr_n), .RTS_N_OUT(rts_n), .RX_ABOVE_TRIG_IN(trig), .TX_ENABLE_OUT(tx_en),
    .FAST_IR_RECEIVE_IN(fir), .SLOW_IR_RECEIVE_IN(sir), .IR_RX_DATA_OUT(ir_rx),
    .DMA_SRC_REQ_IN(src), .DACK_N_IN(dack_n), .DRQ_OUT(drq), .IRQ_OUT(irq));
  msh_dma_model msh_dma_model_inst (.clk_in(clk), .rst_in(rst), .drq_in(drq), .lat_in(lat),
    .dack_n_out(dack_n));

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    din <= d;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask

  // the note goes in first so the watcher always finds it
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    rd <= 1'b1;
    addr <= a;
    cyc(1);
    rd <= 1'b0;
    cyc(1);
  endtask

  // falling edge: read data stand one cycle only
  always @(negedge clk) begin
    if (doe === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("CHECK FAILED %0t unexpected read data", $time);
      end else begin
        chk({3'h0, dout}, {3'h0, exp_q.pop_front()});
      end
    end
  end

  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    void'($urandom(10));
    lat <= 4'($urandom_range(5, 2));
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    chk({dtr_n, rts_n, tx_en, ir_rx}, 11'hF);
    chk({drq, irq}, 11'h0);
    rd_reg(ADR_MCTL, 8'h00);
    rd_reg(ADR_ICR, 8'h0F);
    rd_reg(ADR_MSTAT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      mpin_n[i] <= 1'b0;
      cyc(3);
      rd_reg(ADR_MSTAT, 8'(16 << i) | ((i == MI_RI) ? 8'h00 : 8'(1 << i)));
      mpin_n[i] <= 1'b1;
      cyc(3);
      rd_reg(ADR_MSTAT, 8'(1 << i));
      rd_reg(ADR_MSTAT, 8'h00);
    end
    rd_reg(ADR_ISTAT, 8'h01);
    wr_reg(ADR_ICLR, 8'h01);
    rd_reg(ADR_ISTAT, 8'h00);
    sel = 4'($urandom_range(10, 0));
    wr_reg(ADR_ICR, {4'h0, sel});
    rd_reg(ADR_ICR, {4'h0, sel});
    wr_reg(ADR_IEN, 8'h01);
    mpin_n[MI_DCD] <= 1'b0;
    mpin_n[MI_DSR] <= 1'b0;
    cyc(6);
    chk(irq, 11'(1 << sel));
    mpin_n[MI_DCD] <= 1'b1;
    mpin_n[MI_DSR] <= 1'b1;
    wr_reg(ADR_IEN, 8'h00);
    cyc(4);
    chk(irq, 11'h0);
    wr_reg(ADR_ICR, 8'h0C);
    wr_reg(ADR_IEN, 8'h01);
    cyc(2);
    chk(irq, 11'h0);
    wr_reg(ADR_ICLR, 8'h01);
    rd_reg(ADR_MSTAT, 8'h0A);
    wr_reg(ADR_MCTL, 8'h20);
    mpin_n[MI_CTS] <= 1'b0;
    cyc(3);
    chk(tx_en, 11'h1);
    mpin_n[MI_CTS] <= 1'b1;
    cyc(3);
    chk(tx_en, 11'h0);
    rd_reg(ADR_ISTAT, 8'h00);
    rd_reg(ADR_MSTAT, 8'h01);
    wr_reg(ADR_MCTL, 8'h22);
    trig <= 1'b1;
    cyc(3);
    chk(rts_n, 11'h1);
    trig <= 1'b0;
    cyc(3);
    chk(rts_n, 11'h0);
    wr_reg(ADR_MCTL, 8'h01);
    cyc(1);
    chk({dtr_n, rts_n}, 11'h1);
    wr_reg(ADR_MCTL, 8'h13);
    cyc(1);
    chk({dtr_n, rts_n}, 11'h3);
    rd_reg(ADR_MCTL, 8'h13);
    wr_reg(ADR_MCTL, 8'h02);
    cyc(1);
    chk({dtr_n, rts_n}, 11'h2);
    cs_n <= 1'b1;
    wr_reg(ADR_MCTL, 8'h00);
    cs_n <= 1'b0;
    rd_reg(ADR_MCTL, 8'h02);
    rd_reg(4'hF, 8'h00);
    rd_reg(ADR_ICLR, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr_reg(ADR_DCS, 8'(k));
      wr_reg(ADR_DEN, 8'h01);
      src <= 1'b1;
      cyc(2);
      chk(drq, dmap[k]);
      cyc(12);
      src <= 1'b0;
      wr_reg(ADR_DEN, 8'h00);
      cyc(2);
      rd_reg(ADR_ISTAT, (k == 2) ? 8'h00 : 8'h02);
      wr_reg(ADR_ICLR, 8'h02);
    end
    src <= 1'b1;
    cyc(3);
    chk(drq, 11'h0);
    src <= 1'b0;
    for (int m = 0; m < 5; m++) begin
      wr_reg(ADR_IRMODE, 8'(m));
      b = 1'($urandom);
      fir <= b;
      sir <= ~b;
      cyc(2);
      chk({10'h000, ir_rx}, (m == 1 || m == 2) ? {10'h000, b} : {10'h000, ~b});
    end
    cyc(4);
    complete_run();
  end
endmodule // msh_top_tb
